//--- rtl/opatr_amp_if.sv
// Purpose: link between the bus front end and one amplifier register
// Assumes: one instance per amplifier
// Notes: write strobe is a one-cycle pulse
`timescale 1ns/1ps

interface opatr_amp_if;
  logic       wr_en;
  logic [7:0] wdata;
  logic       amp_out;
  logic [7:0] rdata;
  logic       enable;
  logic       cancel_mode;
  logic       ref_select;
  logic [3:0] trim;

  modport ctrl (
    output wr_en,
    output wdata,
    output amp_out,
    input  rdata,
    input  enable,
    input  cancel_mode,
    input  ref_select,
    input  trim
  );

  modport amp (
    input  wr_en,
    input  wdata,
    input  amp_out,
    output rdata,
    output enable,
    output cancel_mode,
    output ref_select,
    output trim
  );
endinterface

//--- rtl/opatr_amp_reg.sv
// Purpose: one amplifier offset control register
// Assumes: rst_n already synchronised to clk
// Notes: bit 6 is live amplifier output, never stored
`timescale 1ns/1ps
`include "opatr_regs.svh"

module opatr_amp_reg (
  input wire logic   clk,
  input wire logic   rst_n,
  opatr_amp_if.amp   bus
);
  import opatr_pkg::*;

  opatr_amp_state_t st_r;
  opatr_amp_state_t st_nxt;

  // =====================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    if (bus.wr_en) begin
      st_nxt.ctrl = bus.wdata;
      st_nxt.ctrl[`OPATR_BIT_OUT] = 1'b0;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.ctrl <= `OPATR_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // fields out
  // live output status
  assign bus.rdata       = {st_r.ctrl[`OPATR_BIT_EN], bus.amp_out,
                            st_r.ctrl[`OPATR_BIT_MODE:`OPATR_TRIM_LO]};
  assign bus.enable      = st_r.ctrl[`OPATR_BIT_EN];
  assign bus.cancel_mode = st_r.ctrl[`OPATR_BIT_MODE];
  assign bus.ref_select  = st_r.ctrl[`OPATR_BIT_REF];
  assign bus.trim        = st_r.ctrl[`OPATR_TRIM_HI:`OPATR_TRIM_LO];

endmodule

//--- rtl/opatr_pkg.sv
// Purpose: shared types of the amplifier trim and routing block
// Assumes: constants come from the _regs header
// Notes: bus states follow a Gray sequence
`include "opatr_regs.svh"

package opatr_pkg;

  typedef enum logic [1:0] {
    OPATR_IDLE = `OPATR_ST_IDLE,
    OPATR_ACK  = `OPATR_ST_ACK
  } opatr_bus_st_t;

  typedef struct packed {
    logic [7:0] ctrl;
  } opatr_amp_state_t;

  typedef struct packed {
    opatr_bus_st_t bus_st;
    logic [31:0]   rdata;
    logic [7:0]    sw;
    logic [7:0]    pin;
    logic [7:0]    mux;
  } opatr_top_state_t;

endpackage

//--- rtl/opatr_regs.svh
// Purpose: offsets, field positions, reset values and codes for the amplifier trim and routing registers
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, 8-bit registers in the low byte lane
// Notes: Notes on behaviour follow
`ifndef OPATR_REGS_SVH
`define OPATR_REGS_SVH

// =====================================================================
// register map
`define OPATR_OFS_AMP_ZERO  8'h00
`define OPATR_OFS_AMP_ONE   8'h04
`define OPATR_OFS_SWITCH    8'h08
`define OPATR_OFS_PIN       8'h0C
`define OPATR_OFS_MUX       8'h10

// =====================================================================
// amplifier register fields
`define OPATR_BIT_EN        7
`define OPATR_BIT_OUT       6
`define OPATR_BIT_MODE      5
`define OPATR_BIT_REF       4
`define OPATR_TRIM_HI       3
`define OPATR_TRIM_LO       0

// =====================================================================
// switch, pin and mux register fields
`define OPATR_BIT_CMP_OUT   0
`define OPATR_BIT_SW_ONE    1
`define OPATR_BIT_SW_TWO    2
`define OPATR_BIT_SW_THREE  3
`define OPATR_SW2_HI        7
`define OPATR_SW2_LO        4
`define OPATR_BIT_CMP_POS   1
`define OPATR_BIT_CMP_NEG   0
`define OPATR_PIN_MASK      8'h03
`define OPATR_MUX_POS_HI    7
`define OPATR_MUX_POS_LO    5
`define OPATR_MUX_LOW_HI    4
`define OPATR_MUX_LOW_LO    0

// =====================================================================
// reset values and bus codes
`define OPATR_RST_BYTE      8'h00
`define OPATR_RST_WORD      32'h0000_0000
`define OPATR_ST_IDLE       2'h0
`define OPATR_ST_ACK        2'h1
`define OPATR_BYTE_LANE     0

`endif

//--- rtl/opatr_top.sv
// Purpose: register bank for two amplifiers, switches, mux and comparator pins
// Assumes: Avalon-MM master per standard, one clock
// Notes: one wait cycle per access, unmapped reads return zero
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "opatr_regs.svh"

module opatr_top (
  input  wire logic        CLK,
  input  wire logic        RST_N,

  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,

  input  wire logic        AMP_ZERO_OUT,
  input  wire logic        AMP_ONE_OUT,

  output logic             AMP_ZERO_ENABLE,
  output logic             AMP_ZERO_CANCEL_MODE,
  output logic             AMP_ZERO_REF_SELECT,
  output logic      [3:0]  AMP_ZERO_TRIM,

  output logic             AMP_ONE_ENABLE,
  output logic             AMP_ONE_CANCEL_MODE,
  output logic             AMP_ONE_REF_SELECT,
  output logic      [3:0]  AMP_ONE_TRIM,

  output logic             CMP_POS_PIN_ENABLE,
  output logic             CMP_POS_PIN_PULLUP_DIS,
  output logic             CMP_NEG_PIN_ENABLE,
  output logic             CMP_NEG_PIN_PULLUP_DIS,
  output logic             CMP_OUT_PIN_ENABLE,

  output logic             SWITCH_ONE_ONE,
  output logic             SWITCH_ONE_TWO,
  output logic             SWITCH_ONE_THREE,
  output logic      [3:0]  SWITCH_TWO_BANK,

  output logic      [2:0]  AMP_ZERO_POS_SELECTOR,
  output logic      [4:0]  AMP_ZERO_MUX_LOW
);
  import opatr_pkg::*;

  // =====================================================================
  // reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // =====================================================================
  // declarations
  opatr_top_state_t st_r;
  opatr_top_state_t st_nxt;

  logic       req;
  logic       commit;
  logic       wr_commit;
  logic       lane_ok;
  logic [7:0] wbyte;

  logic       hit_amp_zero;
  logic       hit_amp_one;
  logic       hit_switch;
  logic       hit_pin;
  logic       hit_mux;

  logic [1:0] amp_hit;
  logic [1:0] amp_out_in;
  logic [7:0] amp_rdata   [2];
  logic [1:0] amp_enable;
  logic [1:0] amp_mode;
  logic [1:0] amp_ref;
  logic [3:0] amp_trim    [2];

  logic [7:0] rd_byte;

  // =====================================================================
  // address decode
  assign hit_amp_zero = (AVS_ADDRESS == `OPATR_OFS_AMP_ZERO);
  assign hit_amp_one  = (AVS_ADDRESS == `OPATR_OFS_AMP_ONE);
  assign hit_switch   = (AVS_ADDRESS == `OPATR_OFS_SWITCH);
  assign hit_pin      = (AVS_ADDRESS == `OPATR_OFS_PIN);
  assign hit_mux      = (AVS_ADDRESS == `OPATR_OFS_MUX);

  assign amp_hit      = {hit_amp_one, hit_amp_zero};
  assign amp_out_in   = {AMP_ONE_OUT, AMP_ZERO_OUT};

  // =====================================================================
  // handshake
  assign req       = AVS_READ | AVS_WRITE;
  assign commit    = req & (st_r.bus_st == OPATR_ACK);
  assign lane_ok   = AVS_BYTEENABLE[`OPATR_BYTE_LANE];
  assign wr_commit = commit & AVS_WRITE & lane_ok;
  assign wbyte     = AVS_WRITEDATA[7:0];

  // waitrequest falls only in the acknowledge cycle
  assign AVS_WAITREQUEST = req & (st_r.bus_st != OPATR_ACK);
  assign AVS_READDATA    = st_r.rdata;

  // =====================================================================
  // amplifier registers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gen_amp
      opatr_amp_if u_if ();

      assign u_if.wr_en   = wr_commit & amp_hit[gi];
      assign u_if.wdata   = wbyte;
      assign u_if.amp_out = amp_out_in[gi];

      assign amp_rdata[gi]  = u_if.rdata;
      assign amp_enable[gi] = u_if.enable;
      assign amp_mode[gi]   = u_if.cancel_mode;
      assign amp_ref[gi]    = u_if.ref_select;
      assign amp_trim[gi]   = u_if.trim;

      opatr_amp_reg u_amp (
        .clk   (CLK),
        .rst_n (rst_n),
        .bus   (u_if.amp)
      );
    end
  endgenerate

  // =====================================================================
  // read mux
  always_comb begin
    rd_byte = `OPATR_RST_BYTE;
    case (1'b1)
      hit_amp_zero: begin
        rd_byte = amp_rdata[0];
      end
      hit_amp_one: begin
        rd_byte = amp_rdata[1];
      end
      hit_switch: begin
        rd_byte = st_r.sw;
      end
      hit_pin: begin
        rd_byte = st_r.pin;
      end
      hit_mux: begin
        rd_byte = st_r.mux;
      end
      default: begin
        rd_byte = `OPATR_RST_BYTE;
      end
    endcase
  end

  // =====================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    case (st_r.bus_st)
      OPATR_IDLE: begin
        if (req) begin
          st_nxt.bus_st = OPATR_ACK;
          st_nxt.rdata  = AVS_READ ? {24'h00_0000, rd_byte} : `OPATR_RST_WORD;
        end
      end
      OPATR_ACK: begin
        st_nxt.bus_st = OPATR_IDLE;
      end
      default: begin
        st_nxt.bus_st = OPATR_IDLE;
      end
    endcase

    if (wr_commit) begin
      if (hit_switch) begin
        st_nxt.sw = wbyte;
      end
      if (hit_pin) begin
        st_nxt.pin = wbyte & `OPATR_PIN_MASK;
      end
      if (hit_mux) begin
        st_nxt.mux = wbyte;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r.bus_st <= OPATR_IDLE;
      st_r.rdata  <= `OPATR_RST_WORD;
      st_r.sw     <= `OPATR_RST_BYTE;
      st_r.pin    <= `OPATR_RST_BYTE;
      st_r.mux    <= `OPATR_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // amplifier controls
  // amplifier zero enable
  assign AMP_ZERO_ENABLE      = amp_enable[0];
  assign AMP_ZERO_CANCEL_MODE = amp_mode[0];
  assign AMP_ZERO_REF_SELECT  = amp_ref[0];
  assign AMP_ZERO_TRIM        = amp_trim[0];

  assign AMP_ONE_ENABLE       = amp_enable[1];
  assign AMP_ONE_CANCEL_MODE  = amp_mode[1];
  assign AMP_ONE_REF_SELECT   = amp_ref[1];
  assign AMP_ONE_TRIM         = amp_trim[1];

  // =====================================================================
  // comparator pin sharing
  // positive input takeover
  assign CMP_POS_PIN_ENABLE     = st_r.pin[`OPATR_BIT_CMP_POS];
  assign CMP_POS_PIN_PULLUP_DIS = st_r.pin[`OPATR_BIT_CMP_POS];
  assign CMP_NEG_PIN_ENABLE     = st_r.pin[`OPATR_BIT_CMP_NEG];
  assign CMP_NEG_PIN_PULLUP_DIS = st_r.pin[`OPATR_BIT_CMP_NEG];
  assign CMP_OUT_PIN_ENABLE     = st_r.sw[`OPATR_BIT_CMP_OUT];

  // =====================================================================
  // analog switches and mux
  // one closes switch
  assign SWITCH_ONE_ONE   = st_r.sw[`OPATR_BIT_SW_ONE];
  assign SWITCH_ONE_TWO   = st_r.sw[`OPATR_BIT_SW_TWO];
  assign SWITCH_ONE_THREE = st_r.sw[`OPATR_BIT_SW_THREE];
  assign SWITCH_TWO_BANK  = st_r.sw[`OPATR_SW2_HI:`OPATR_SW2_LO];

  assign AMP_ZERO_POS_SELECTOR = st_r.mux[`OPATR_MUX_POS_HI:`OPATR_MUX_POS_LO];
  assign AMP_ZERO_MUX_LOW      = st_r.mux[`OPATR_MUX_LOW_HI:`OPATR_MUX_LOW_LO];

endmodule

//--- verif/opatr_top_properties.sv
// Purpose: port-level properties of the amplifier trim register bank
// Assumes: one wait cycle per access, register update on the accepting edge
// Notes: bound to opatr_top
`timescale 1ns/1ps

module opatr_props (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        AMP_ZERO_OUT,
  input wire logic        AMP_ZERO_ENABLE,
  input wire logic [3:0]  AMP_ZERO_TRIM,
  input wire logic        AMP_ONE_ENABLE,
  input wire logic        CMP_POS_PIN_ENABLE,
  input wire logic        CMP_POS_PIN_PULLUP_DIS,
  input wire logic        CMP_NEG_PIN_ENABLE,
  input wire logic        CMP_NEG_PIN_PULLUP_DIS,
  input wire logic        SWITCH_ONE_ONE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ===========================================================
  // bus steps
  sequence s_wr(logic [7:0] a);
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == a && AVS_BYTEENABLE[0];
  endsequence
  sequence s_rd_zero_start;
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 8'h00;
  endsequence

  // ===========================================================
  // properties
  a_pos_pull_tied: assert property (CMP_POS_PIN_PULLUP_DIS == CMP_POS_PIN_ENABLE)
    else $error("pos pin pull-high off not tied to enable");
  a_neg_pull_tied: assert property (CMP_NEG_PIN_PULLUP_DIS == CMP_NEG_PIN_ENABLE)
    else $error("neg pin pull-high off not tied to enable");
  a_zero_enable_write: assert property (s_wr(8'h00) |=> AMP_ZERO_ENABLE == $past(AVS_WRITEDATA[7]))
    else $error("amp zero enable did not follow write");
  a_zero_trim_write: assert property (s_wr(8'h00) |=> AMP_ZERO_TRIM == $past(AVS_WRITEDATA[3:0]))
    else $error("amp zero trim did not follow write");
  a_zero_trim_hold: assert property (!(AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h00 && AVS_BYTEENABLE[0])
    |=> $stable(AMP_ZERO_TRIM))
    else $error("amp zero trim changed without write");
  a_one_enable_write: assert property (s_wr(8'h04) |=> AMP_ONE_ENABLE == $past(AVS_WRITEDATA[7]))
    else $error("amp one enable did not follow write");
  a_switch_write: assert property (s_wr(8'h08) |=> SWITCH_ONE_ONE == $past(AVS_WRITEDATA[1]))
    else $error("switch one one did not follow write");
  a_status_read: assert property (s_rd_zero_start |=> AVS_READDATA[6] == $past(AMP_ZERO_OUT))
    else $error("status bit does not show amplifier output");
  a_reset_clear: assert property ($rose(RST_N) |-> !AMP_ZERO_ENABLE && !AMP_ONE_ENABLE && AMP_ZERO_TRIM == 4'h0)
    else $error("outputs not cleared by reset");
endmodule

bind opatr_top opatr_props u_props (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AMP_ZERO_OUT(AMP_ZERO_OUT),
  .AMP_ZERO_ENABLE(AMP_ZERO_ENABLE), .AMP_ZERO_TRIM(AMP_ZERO_TRIM), .AMP_ONE_ENABLE(AMP_ONE_ENABLE),
  .CMP_POS_PIN_ENABLE(CMP_POS_PIN_ENABLE), .CMP_POS_PIN_PULLUP_DIS(CMP_POS_PIN_PULLUP_DIS),
  .CMP_NEG_PIN_ENABLE(CMP_NEG_PIN_ENABLE), .CMP_NEG_PIN_PULLUP_DIS(CMP_NEG_PIN_PULLUP_DIS),
  .SWITCH_ONE_ONE(SWITCH_ONE_ONE));

//--- verif/opatr_top_test.sv
// Purpose: self-checking bench for the amplifier trim register bank
// Assumes: one Avalon-MM master, 50 MHz clock
// Notes: table rows write then read back each register
`timescale 1ns/1ps

module opatr_top_test;
  import opatr_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic o; logic [7:0] rd; logic [7:0] vw;} opatr_row_t;

  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic        z_out = 1'b0;
  logic        o_out = 1'b0;
  logic [31:0] rdata, q;
  logic        wq, z_en, z_cm, z_rs, o_en, o_cm, o_rs, p_en, p_pd, n_en, n_pd, c_out, s1, s2, s3;
  logic [3:0]  z_tr, o_tr, bank;
  logic [2:0]  sel;
  logic [4:0]  mlow;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  // ===========================================================
  // write then read rows
  // switch setups at 0x08, selector 111 then 000 at 0x10
  opatr_row_t rows [14] = '{'{8'h00, 8'hFF, 1'b0, 8'hBF, 8'hBF}, '{8'h00, 8'h5A, 1'b1, 8'h5A, 8'h1A},
    '{8'h00, 8'hA5, 1'b0, 8'hA5, 8'hA5}, '{8'h04, 8'hFF, 1'b1, 8'hFF, 8'hBF}, '{8'h04, 8'h50, 1'b0, 8'h10, 8'h10},
    '{8'h08, 8'h0C, 1'b0, 8'h0C, 8'h0C}, '{8'h08, 8'h0A, 1'b0, 8'h0A, 8'h0A}, '{8'h08, 8'hF5, 1'b0, 8'hF5, 8'hF5},
    '{8'h10, 8'hFF, 1'b0, 8'hFF, 8'hFF}, '{8'h10, 8'h00, 1'b0, 8'h00, 8'h00}, '{8'h0C, 8'hFF, 1'b0, 8'h03, 8'h0F},
    '{8'h0C, 8'h02, 1'b0, 8'h02, 8'h0A}, '{8'h0C, 8'h01, 1'b0, 8'h01, 8'h05}, '{8'h14, 8'hFF, 1'b0, 8'h00, 8'h00}};

  opatr_top u_opatr_top (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq), .AMP_ZERO_OUT(z_out),
    .AMP_ONE_OUT(o_out), .AMP_ZERO_ENABLE(z_en), .AMP_ZERO_CANCEL_MODE(z_cm), .AMP_ZERO_REF_SELECT(z_rs),
    .AMP_ZERO_TRIM(z_tr), .AMP_ONE_ENABLE(o_en), .AMP_ONE_CANCEL_MODE(o_cm), .AMP_ONE_REF_SELECT(o_rs),
    .AMP_ONE_TRIM(o_tr), .CMP_POS_PIN_ENABLE(p_en), .CMP_POS_PIN_PULLUP_DIS(p_pd), .CMP_NEG_PIN_ENABLE(n_en),
    .CMP_NEG_PIN_PULLUP_DIS(n_pd), .CMP_OUT_PIN_ENABLE(c_out), .SWITCH_ONE_ONE(s1), .SWITCH_ONE_TWO(s2),
    .SWITCH_ONE_THREE(s3), .SWITCH_TWO_BANK(bank), .AMP_ZERO_POS_SELECTOR(sel), .AMP_ZERO_MUX_LOW(mlow));

  always #10 CLK = ~CLK;

  // ===========================================================
  // helpers
  // outputs regrouped in register bit order
  function automatic logic [7:0] view(input logic [7:0] a);
    case (a)
      8'h00: return {z_en, 1'b0, z_cm, z_rs, z_tr};
      8'h04: return {o_en, 1'b0, o_cm, o_rs, o_tr};
      8'h08: return {bank, s3, s2, s1, c_out};
      8'h0C: return {4'h0, p_pd, n_pd, p_en, n_en};
      8'h10: return {sel, mlow};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // request held until waitrequest seen low at a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] m,
                     output logic [31:0] r);
    logic ok;
    adr <= a;
    wr_s <= w;
    rd_s <= !w;
    wd <= {24'h00_0000, d};
    be <= m;
    ok = 1'b0;
    while (!ok) begin
      @(posedge CLK);
      ok = (wq === 1'b0);
    end
    // read data taken at the accepting edge
    r = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      tally_and_finish;
    end
  end

  // ===========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    foreach (rows[i]) begin
      z_out <= rows[i].o;
      o_out <= rows[i].o;
      bus(rows[i].a, 1'b1, rows[i].w, 4'hF, q);
      bus(rows[i].a, 1'b0, 8'h00, 4'hF, q);
      chk("readdata", {24'h00_0000, rows[i].rd}, q);
      chk("outputs", {24'h00_0000, rows[i].vw}, {24'h00_0000, view(rows[i].a)});
    end
    bus(8'h00, 1'b1, 8'h00, 4'h0, q);
    bus(8'h00, 1'b0, 8'h00, 4'hF, q);
    chk("dropped write", 32'h0000_00A5, q);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("reset outputs", 32'h0000_0000, {view(8'h00), view(8'h04), view(8'h08), view(8'h0C)});
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    bus(8'h04, 1'b0, 8'h00, 4'hF, q);
    chk("reset readdata", 32'h0000_0000, q);
    tally_and_finish;
  end
endmodule
